// ---- logic_core_cfg.svh ----
// constants of the logic function block core: offsets, fields, reset values, timing
`ifndef LOGIC_CORE_CFG_SVH
`define LOGIC_CORE_CFG_SVH

// register byte offsets
`define OFS_GATE_CFG   8'h00
`define OFS_GATE_STAT  8'h04
`define OFS_SF_CFG     8'h08
`define OFS_SF_PARAM   8'h0c
`define OFS_SF_MSG     8'h10
`define OFS_SF_STAT    8'h14
`define OFS_AN_GAIN    8'h18
`define OFS_AN_OFFSET  8'h1c
`define OFS_AN_STAT    8'h20
`define OFS_RTC_TIME   8'h24
`define OFS_RTC_DATE   8'h28
`define OFS_HOURS      8'h2c

// synchronised pin vector positions
`define PIN_NOR_LSB    0
`define PIN_XOR_LSB    4
`define PIN_NOT        6
`define PIN_SF_LSB     7
`define PIN_REF        13
`define PIN_BACKUP     14

// special-function input positions inside the six-bit group
`define SF_SET         0
`define SF_CLR         1
`define SF_GATE        2
`define SF_INV         3
`define SF_CLRALL      4
`define SF_TRG         5

// sf configuration fields
`define CFG_TB_LSB     6
`define CFG_RET        8
`define CFG_PROT       9
`define CFG_MSGPROT    10
`define CFG_PROG       11
`define CFG_RESTART    12

// reset values of the calendar
`define RST_MDAY       5'h01
`define RST_MON        4'h1

// calendar and timebase limits
`define HUND_MAX       7'h63
`define HUND_HALF      7'h32
`define SEC_MAX        6'h3b
`define HOUR_MAX       5'h17
`define WDAY_MAX       3'h6
`define MON_MAX        4'hc
`define BOOT_SAMPLE    3'h4
`define MULT_SEC       15'h0064
`define MULT_MINHOUR   15'h003c

// analog scaling
`define AN_MV_PER_STEP 14'h000a
`define AN_FULL        11'h3e8
`define GAIN_LIM       16'sh03e8
`define OFS_LIM        16'sh2710
`define AN_GAIN_DIV    28'sh0000064

// timing
`define CLK_PERIOD_NS  25
`define CYCLE_TIME_NS  100000
`define HUND_TIME_NS   10000000

`endif

// ---- logic_core_pkg.sv ----
// types shared by the logic function block core
`default_nettype none
package logic_core_pkg;
   // bus answer phase
   typedef enum logic {APB_IDLE = 1'b0, APB_ANSWER = 1'b1} apb_st_t;
   // timebase of a time parameter
   typedef enum logic [1:0] {TB_SEC = 2'h0, TB_MIN = 2'h1, TB_HOUR = 2'h2} timebase_t;
endpackage
`default_nettype wire

// ---- analog_if.sv ----
// carrier between the core and its analog scaler
`default_nettype none
interface analog_if;
   logic        [13:0] millivolts;  // settled input sample
   logic signed [15:0] gain;        // hundredths
   logic signed [15:0] offset;      // display units
   logic               strobe;      // program-cycle strobe
   logic        [10:0] internal;    // 0..1000
   logic signed [15:0] scaled;      // displayed value
   modport core   (output millivolts, gain, offset, strobe, input internal, scaled);
   modport scaler (input millivolts, gain, offset, strobe, output internal, scaled);
endinterface
`default_nettype wire

// ---- analog_scaler.sv ----
// analog input scaler: voltage to internal value, then gain and offset
`include "logic_core_cfg.svh"
`default_nettype none
module analog_scaler
   import logic_core_pkg::*;
(
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_b_in,
   // values from and to the core
   analog_if.scaler  an
);
   typedef struct packed {
      logic        [10:0] internal;
      logic signed [15:0] scaled;
   } scaler_state_t;

   scaler_state_t      r;      // registered state
   scaler_state_t      r_nxt;  // next state
   logic        [13:0] steps;  // input in tens of millivolts
   logic signed [27:0] prod;   // internal times gain, hundredths
   logic signed [27:0] quot;   // product back in units

   // evaluate once per program cycle
   always_comb begin
      r_nxt = r;
      steps = an.millivolts / `AN_MV_PER_STEP;
      prod  = '0;
      quot  = '0;
      if (an.strobe) begin
         // above full scale the value saturates
         if (steps > 14'(`AN_FULL)) begin
            r_nxt.internal = `AN_FULL;
         end else begin
            r_nxt.internal = steps[10:0];
         end
         // division truncates toward zero, so tiny products show as zero
         prod = 28'($signed({1'b0, r_nxt.internal})) * 28'(an.gain);
         quot = prod / `AN_GAIN_DIV;
         r_nxt.scaled = 16'(quot) + an.offset;
      end
   end

   // state register
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign an.internal = r.internal;
   assign an.scaled   = r.scaled;
endmodule // analog_scaler
`default_nettype wire

// ---- logic_core.sv ----
// logic function block core: gates, special function, calendar, analog, apb slave
`include "logic_core_cfg.svh"
`default_nettype none
module logic_core
   import logic_core_pkg::*;
#(
   parameter int HUND_CNT = `HUND_TIME_NS / `CLK_PERIOD_NS  // clocks per hundredth second
) (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // input terminals
   input  wire logic [3:0]  nor_term_in,
   input  wire logic [1:0]  xor_term_in,
   input  wire logic        not_term_in,
   input  wire logic        set_term_in,
   input  wire logic        clear_term_in,
   input  wire logic        gate_term_in,
   input  wire logic        invert_term_in,
   input  wire logic        clear_all_term_in,
   input  wire logic        trigger_term_in,
   input  wire logic        ref_second_in,
   input  wire logic        backup_lost_in,
   input  wire logic [13:0] analog_input_terminal_in,
   // output terminals
   output logic             nor_q_out,
   output logic             xor_q_out,
   output logic             not_q_out,
   output logic             sf_q_out,
   output logic             clock_stopped_out,
   output logic             clock_flash_out,
   output logic      [15:0] scaled_analog_value_out
);
   localparam int         CYCLE_CNT = `CYCLE_TIME_NS / `CLK_PERIOD_NS;
   localparam logic [11:0] CYC_LAST  = 12'(CYCLE_CNT - 1);
   localparam logic [18:0] HUND_LAST = 19'(HUND_CNT - 1);

   typedef struct packed {
      apb_st_t            apb_st;   // bus answer phase
      logic        [31:0] prdata;   // read data
      logic               pready;   // answer strobe
      logic               pslverr;  // unmapped address
      logic        [14:0] dig_s1;   // synchroniser stage one
      logic        [14:0] dig_s2;
      logic        [14:0] dig_s3;
      logic        [14:0] dig_f;    // settled pin levels
      logic        [13:0] an_s1;
      logic        [13:0] an_s2;
      logic        [13:0] an_s3;
      logic        [13:0] an_f;     // settled analog word
      logic               ref_prev; // previous reference level
      logic        [11:0] cyc_div;  // program-cycle divider
      logic        [18:0] hund_div; // hundredth divider
      logic        [6:0]  hund;
      logic        [5:0]  sec_free; // never stops, feeds timers
      logic        [5:0]  sec;
      logic        [5:0]  min;
      logic        [4:0]  hour;
      logic        [2:0]  wday;     // zero is sunday
      logic        [4:0]  mday;
      logic        [3:0]  mon;
      logic               stopped;
      logic               flash;
      logic        [2:0]  boot;     // counts edges after reset release
      logic        [6:0]  gate_cfg; // connected mask of gate inputs
      logic        [11:0] sf_cfg;
      logic        [7:0]  t_hi;
      logic        [7:0]  t_lo;
      logic        [14:0] elapsed;
      logic               base_pend;
      logic               sf_q;     // internal switching state
      logic               sf_out;
      logic        [2:0]  gate_q;   // nor, xor, not
      logic signed [15:0] gain;
      logic signed [15:0] offset;
      logic        [5:0]  hrs_min;
      logic        [19:0] hours;
   } core_state_t;

   core_state_t r;          // registered state
   core_state_t r_nxt;      // next state
   logic [14:0] dig_pins;   // raw pin vector
   logic        cyc_stb;    // program-cycle strobe
   logic        hund_tick;
   logic        ref_rise;
   logic        sec_tick;
   logic        min_tick;
   logic        base_tick;
   logic [5:0]  sf_in;      // masked special-function inputs
   logic [14:0] target;     // time parameter as a count of base ticks
   logic [31:0] rd;         // read mux
   logic        prot_block;
   logic        msg_block;

   analog_if an ();

   // word-aligned map check, shared by read answer and write gating
   function automatic logic is_mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `OFS_HOURS);
   endfunction

   // symmetric saturation of a signed value
   function automatic logic signed [15:0] clamp16(input logic signed [15:0] v,
                                                  input logic signed [15:0] lim);
      if (v > lim) begin
         return lim;
      end else if (v < -lim) begin
         return -lim;
      end
      return v;
   endfunction

   // time parameter to a count of base ticks
   function automatic logic [14:0] param_units(input logic [1:0] tb,
                                               input logic [7:0] hi,
                                               input logic [7:0] lo);
      logic [14:0] mult;
      mult = (tb == TB_SEC) ? `MULT_SEC : `MULT_MINHOUR;
      return 15'(15'(hi) * mult + 15'(lo));
   endfunction

   // days in a month, february fixed at 28
   function automatic logic [4:0] month_days(input logic [3:0] m);
      if (m == 4'h2) begin
         return 5'h1c;
      end else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb) begin
         return 5'h1e;
      end
      return 5'h1f;
   endfunction

   assign dig_pins = {backup_lost_in, ref_second_in, trigger_term_in, clear_all_term_in,
                      invert_term_in, gate_term_in, clear_term_in, set_term_in,
                      not_term_in, xor_term_in, nor_term_in};

   // next-state logic for the whole core
   always_comb begin
      r_nxt = r;
      // pins pass three stages; a high counts once stages two and three agree, a low as soon as they differ
      r_nxt.dig_s1 = dig_pins;
      r_nxt.dig_s2 = r.dig_s1;
      r_nxt.dig_s3 = r.dig_s2;
      r_nxt.dig_f  = (r.dig_s2 & r.dig_s3) | (r.dig_f & ~(r.dig_s2 ^ r.dig_s3));
      r_nxt.an_s1  = analog_input_terminal_in;
      r_nxt.an_s2  = r.an_s1;
      r_nxt.an_s3  = r.an_s2;
      // whole-word agreement avoids mixing bits of two samples
      if (r.an_s2 == r.an_s3) begin
         r_nxt.an_f = r.an_s3;
      end
      // program-cycle strobe
      cyc_stb = (r.cyc_div == CYC_LAST);
      r_nxt.cyc_div = cyc_stb ? 12'h000 : r.cyc_div + 12'h001;
      // hundredths, realigned on each reference second
      hund_tick = 1'b0;
      sec_tick  = 1'b0;
      ref_rise  = r.dig_f[`PIN_REF] & ~r.ref_prev & (r.boot > `BOOT_SAMPLE);
      r_nxt.ref_prev = r.dig_f[`PIN_REF];
      if (ref_rise) begin
         // a lagging local second is issued now, a leading one is not repeated
         r_nxt.hund_div = '0;
         r_nxt.hund     = '0;
         sec_tick       = (r.hund >= `HUND_HALF);
      end else if (r.hund_div == HUND_LAST) begin
         r_nxt.hund_div = '0;
         hund_tick      = 1'b1;
         if (r.hund == `HUND_MAX) begin
            r_nxt.hund = '0;
            sec_tick   = 1'b1;
         end else begin
            r_nxt.hund = r.hund + 7'h01;
         end
      end else begin
         r_nxt.hund_div = r.hund_div + 19'h00001;
      end
      min_tick = sec_tick && (r.sec_free == `SEC_MAX);
      if (sec_tick) begin
         r_nxt.sec_free = (r.sec_free == `SEC_MAX) ? 6'h00 : r.sec_free + 6'h01;
      end
      // calendar, frozen while stopped
      if (sec_tick && !r.stopped) begin
         if (r.sec != `SEC_MAX) begin
            r_nxt.sec = r.sec + 6'h01;
         end else begin
            r_nxt.sec = '0;
            if (r.min != `SEC_MAX) begin
               r_nxt.min = r.min + 6'h01;
            end else begin
               r_nxt.min = '0;
               if (r.hour != `HOUR_MAX) begin
                  r_nxt.hour = r.hour + 5'h01;
               end else begin
                  r_nxt.hour = '0;
                  r_nxt.wday = (r.wday == `WDAY_MAX) ? 3'h0 : r.wday + 3'h1;
                  if (r.mday == month_days(r.mon)) begin
                     r_nxt.mday = `RST_MDAY;
                     r_nxt.mon  = (r.mon == `MON_MAX) ? `RST_MON : r.mon + 4'h1;
                  end else begin
                     r_nxt.mday = r.mday + 5'h01;
                  end
               end
            end
         end
      end
      r_nxt.flash = r.stopped & (r.hund < `HUND_HALF);
      // backup state is read once the synchroniser has settled after reset
      if (r.boot != 3'h7) begin
         r_nxt.boot = r.boot + 3'h1;
      end
      if (r.boot == `BOOT_SAMPLE && r.dig_f[`PIN_BACKUP]) begin
         r_nxt.sec     = '0;
         r_nxt.min     = '0;
         r_nxt.hour    = '0;
         r_nxt.wday    = '0;
         r_nxt.mday    = `RST_MDAY;
         r_nxt.mon     = `RST_MON;
         r_nxt.stopped = 1'b1;
      end
      // base tick for the time parameter, held until the next cycle
      case (timebase_t'(r.sf_cfg[`CFG_TB_LSB +: 2]))
         TB_SEC:  base_tick = hund_tick;
         TB_MIN:  base_tick = sec_tick;
         default: base_tick = min_tick;
      endcase
      if (cyc_stb) begin
         r_nxt.base_pend = 1'b0;
      end
      // a tick in the clearing cycle is kept
      if (base_tick) begin
         r_nxt.base_pend = 1'b1;
      end
      target = param_units(r.sf_cfg[`CFG_TB_LSB +: 2], r.t_hi, r.t_lo);
      sf_in  = r.dig_f[`PIN_SF_LSB +: 6] & r.sf_cfg[5:0];
      // evaluation on the cycle strobe
      if (cyc_stb) begin
         r_nxt.gate_q[0] = ~|(r.dig_f[`PIN_NOR_LSB +: 4] & r.gate_cfg[3:0]);
         r_nxt.gate_q[1] = ^(r.dig_f[`PIN_XOR_LSB +: 2] & r.gate_cfg[5:4]);
         r_nxt.gate_q[2] = ~(r.dig_f[`PIN_NOT] & r.gate_cfg[6]);
         if (sf_in[`SF_CLR]) begin
            r_nxt.sf_q    = 1'b0;
            r_nxt.elapsed = '0;
            r_nxt.sf_out  = 1'b0;
         end else if (!sf_in[`SF_GATE]) begin
            r_nxt.sf_q = r.sf_q;
         end else begin
            if (sf_in[`SF_CLRALL]) begin
               r_nxt.sf_q    = 1'b0;
               r_nxt.elapsed = '0;
            end else if (sf_in[`SF_SET]) begin
               r_nxt.sf_q = 1'b1;
            end else if (sf_in[`SF_TRG]) begin
               if (r.elapsed >= target) begin
                  r_nxt.sf_q = 1'b1;
               end else if (r.base_pend) begin
                  r_nxt.elapsed = r.elapsed + 15'h0001;
               end
            end else begin
               r_nxt.elapsed = '0;
            end
            r_nxt.sf_out = r_nxt.sf_q ^ sf_in[`SF_INV];
         end
      end
      // operating hours of the function output, never cleared by a restart
      if (min_tick && r.sf_out) begin
         if (r.hrs_min == `SEC_MAX) begin
            r_nxt.hrs_min = '0;
            r_nxt.hours   = r.hours + 20'h00001;
         end else begin
            r_nxt.hrs_min = r.hrs_min + 6'h01;
         end
      end
      // parameter views
      prot_block = r.sf_cfg[`CFG_PROT] & ~r.sf_cfg[`CFG_PROG];
      msg_block  = r.sf_cfg[`CFG_MSGPROT] & ~r.sf_cfg[`CFG_PROG];
      // read mux
      if (paddr_in == `OFS_GATE_CFG) begin
         rd = {25'h0, r.gate_cfg};
      end else if (paddr_in == `OFS_GATE_STAT) begin
         rd = {29'h0, r.gate_q};
      end else if (paddr_in == `OFS_SF_CFG) begin
         rd = {20'h0, r.sf_cfg};
      end else if (paddr_in == `OFS_SF_PARAM) begin
         rd = prot_block ? 32'h0 : {16'h0, r.t_hi, r.t_lo};
      end else if (paddr_in == `OFS_SF_MSG) begin
         rd = msg_block ? 32'h0 : {16'h0, r.t_hi, r.t_lo};
      end else if (paddr_in == `OFS_SF_STAT) begin
         rd = {1'b0, r.elapsed, 14'h0, r.sf_q, r.sf_out};
      end else if (paddr_in == `OFS_AN_GAIN) begin
         rd = {{16{r.gain[15]}}, r.gain};
      end else if (paddr_in == `OFS_AN_OFFSET) begin
         rd = {{16{r.offset[15]}}, r.offset};
      end else if (paddr_in == `OFS_AN_STAT) begin
         rd = {an.scaled, 5'h0, an.internal};
      end else if (paddr_in == `OFS_RTC_TIME) begin
         rd = {r.stopped, 4'h0, r.wday, 3'h0, r.hour, 2'h0, r.min, 2'h0, r.sec};
      end else if (paddr_in == `OFS_RTC_DATE) begin
         rd = {20'h0, r.mon, 3'h0, r.mday};
      end else if (paddr_in == `OFS_HOURS) begin
         rd = {12'h0, r.hours};
      end else begin
         rd = 32'h0;
      end
      // apb: answer one cycle into the access phase, act on the sampled pready
      r_nxt.pready  = 1'b0;
      r_nxt.pslverr = 1'b0;
      case (r.apb_st)
         APB_IDLE: begin
            if (psel_in && penable_in) begin
               r_nxt.apb_st  = APB_ANSWER;
               r_nxt.pready  = 1'b1;
               r_nxt.pslverr = !is_mapped(paddr_in);
               r_nxt.prdata  = (pwrite_in || !is_mapped(paddr_in)) ? 32'h0 : rd;
            end
         end
         APB_ANSWER: begin
            r_nxt.apb_st = APB_IDLE;
            if (psel_in && penable_in && pwrite_in && is_mapped(paddr_in)) begin
               if (paddr_in == `OFS_GATE_CFG) begin
                  r_nxt.gate_cfg = pwdata_in[6:0];
               end else if (paddr_in == `OFS_SF_CFG) begin
                  r_nxt.sf_cfg = pwdata_in[11:0];
                  // restart: only a retentive function keeps its data
                  if (pwdata_in[`CFG_RESTART] && !r.sf_cfg[`CFG_RET]) begin
                     r_nxt.sf_q      = 1'b0;
                     r_nxt.sf_out    = 1'b0;
                     r_nxt.elapsed   = '0;
                     r_nxt.base_pend = 1'b0;
                  end
               end else if (paddr_in == `OFS_SF_PARAM) begin
                  if (!prot_block) begin
                     r_nxt.t_lo = pwdata_in[7:0];
                     r_nxt.t_hi = pwdata_in[15:8];
                  end
               end else if (paddr_in == `OFS_SF_MSG) begin
                  if (!msg_block) begin
                     r_nxt.t_lo = pwdata_in[7:0];
                     r_nxt.t_hi = pwdata_in[15:8];
                  end
               end else if (paddr_in == `OFS_AN_GAIN) begin
                  r_nxt.gain = clamp16(pwdata_in[15:0], `GAIN_LIM);
               end else if (paddr_in == `OFS_AN_OFFSET) begin
                  r_nxt.offset = clamp16(pwdata_in[15:0], `OFS_LIM);
               end else if (paddr_in == `OFS_RTC_TIME) begin
                  r_nxt.sec      = pwdata_in[5:0];
                  r_nxt.min      = pwdata_in[13:8];
                  r_nxt.hour     = pwdata_in[20:16];
                  r_nxt.wday     = pwdata_in[26:24];
                  r_nxt.hund     = '0;
                  r_nxt.hund_div = '0;
                  r_nxt.stopped  = (r.boot == `BOOT_SAMPLE) && r.dig_f[`PIN_BACKUP];
               end else if (paddr_in == `OFS_RTC_DATE) begin
                  r_nxt.mday = pwdata_in[4:0];
                  r_nxt.mon  = pwdata_in[11:8];
               end
            end
         end
         default: r_nxt.apb_st = APB_IDLE;
      endcase
   end

   // state register; reset leaves sunday 00:00 1 january, non-retentive, unprotected
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r        <= '0;
         r.mday   <= `RST_MDAY;
         r.mon    <= `RST_MON;
         r.gate_q <= 3'h5;
      end else begin
         r <= r_nxt;
      end
   end

   // analog path
   assign an.millivolts = r.an_f;
   assign an.gain       = r.gain;
   assign an.offset     = r.offset;
   assign an.strobe     = cyc_stb;

   analog_scaler u_scaler (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .an       (an.scaler)
   );

   // outputs straight from the state register, the scaled value from the scaler's register
   assign prdata_out              = r.prdata;
   assign pready_out              = r.pready;
   assign pslverr_out             = r.pslverr;
   assign nor_q_out               = r.gate_q[0];
   assign xor_q_out               = r.gate_q[1];
   assign not_q_out               = r.gate_q[2];
   assign sf_q_out                = r.sf_out;
   assign clock_stopped_out       = r.stopped;
   assign clock_flash_out         = r.flash;
   assign scaled_analog_value_out = an.scaled;
endmodule // logic_core
`default_nettype wire

// ---- term_model.sv ----
// terminal model: presents requested pin levels just after each edge
`default_nettype none
module term_model (
   // clock and requested levels
   input  wire logic        mclk_in,
   input  wire logic [12:0] level_in,
   // terminal pins
   output logic      [12:0] pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins move only after an edge, so no race against the sampling flops
   always_ff @(posedge mclk_in) begin
      pins_out <= level_in;
   end
endmodule // term_model
`default_nettype wire

// ---- logic_core_sva.sv ----
// port assertions of the logic core
`default_nettype none
module logic_core_sva (
   // clock, reset and bus
   input wire logic        mclk_in,
   input wire logic        rst_b_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic [7:0]  paddr_in,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // terminals
   input wire logic        not_term_in,
   input wire logic        nor_q_out,
   input wire logic        xor_q_out,
   input wire logic        not_q_out,
   input wire logic        sf_q_out,
   input wire logic        clock_stopped_out,
   input wire logic        clock_flash_out,
   input wire logic [15:0] scaled_analog_value_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   AST_READY_PULSE: assert property (pready_out |=> !pready_out)
      else $error("pready too long");
   AST_READY_ACCESS: assert property (pready_out |-> psel_in && penable_in)
      else $error("pready outside access");
   AST_ANSWER_TWO: assert property (psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
      else $error("answer not in second access cycle");
   AST_ERR_MAP: assert property (pready_out |->
      pslverr_out == (paddr_in[1:0] != 2'h0 || paddr_in > 8'h2c))
      else $error("pslverr wrong");
   // only trusted when the pin had the same level two and eight cycles back
   AST_NOT_Q: assert property ($rose(not_q_out) && $past(not_term_in, 2) == $past(not_term_in, 8)
      |-> $past(not_term_in, 2) == 1'b0)
      else $error("inverter high for high input");
   AST_FLASH: assert property (clock_flash_out |-> clock_stopped_out)
      else $error("flash while running");
   AST_SCALED: assert property ($signed(scaled_analog_value_out) <= 16'sh4e20
      && $signed(scaled_analog_value_out) >= -16'sh4e20)
      else $error("scaled out of range");
   AST_OUTS_HOLD: assert property ($changed({nor_q_out, xor_q_out, not_q_out, sf_q_out})
      |=> $stable({nor_q_out, xor_q_out, not_q_out, sf_q_out})[*8])
      else $error("outputs not held for the cycle");
endmodule // logic_core_sva
bind logic_core logic_core_sva u_sva (.*);
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench of the logic function block core
`include "logic_core_cfg.svh"
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, e;
   logic        pwrite_in = 1'b0, backup_lost_in = 1'b0, pready_out, pslverr_out, ref_sec = 1'b0;
   logic        nor_q_out, xor_q_out, not_q_out, sf_q_out, clock_stopped_out, clock_flash_out;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h00000000, prdata_out, q;
   logic [12:0] level = 13'h0000, pins;
   logic [13:0] analog_input_terminal_in = 14'h0000;
   logic [15:0] scaled_analog_value_out;
   // rows: pins {sf6,not,xor2,nor4} then expected {sf,not,xor,nor}
   logic [16:0] rows [11] = '{17'h02005, 17'h02d1a, 17'h06a86, 17'h03f01, 17'h0284c,
      17'h1812e, 17'h0a6f2, 17'h0280d, 17'h01730, 17'h0600d, 17'h12107};
   wire logic [3:0] outs = {sf_q_out, not_q_out, xor_q_out, nor_q_out};
   int          errors = 0, checks_done = 0;
   always #12.5 mclk_in = ~mclk_in;
   term_model u_term (.mclk_in(mclk_in), .level_in(level), .pins_out(pins));
   logic_core #(.HUND_CNT(20)) u_dut (.*, .nor_term_in(pins[3:0]), .xor_term_in(pins[5:4]),
      .not_term_in(pins[6]), .set_term_in(pins[7]), .clear_term_in(pins[8]),
      .gate_term_in(pins[9]), .invert_term_in(pins[10]), .clear_all_term_in(pins[11]),
      .trigger_term_in(pins[12]), .ref_second_in(ref_sec));
   task automatic clk(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in) penable_in <= 1'b1;
      do @(posedge mclk_in); while (pready_out !== 1'b1);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      clk(6);
      rst_b_in <= 1'b1;
      clk(1);
      apb(1'b1, `OFS_GATE_CFG, 32'h0000007f);
      apb(1'b1, `OFS_SF_CFG, 32'h0000001f);
      apb(1'b0, `OFS_RTC_DATE, 32'h0);
      `CHK("rtc date", 32'h00000101, q)
      apb(1'b0, 8'h30, 32'h0);
      `CHK("unmapped", 1'b1, e)
      foreach (rows[i]) begin
         level <= rows[i][16:4];
         clk(4010);
         `CHK("outs", rows[i][3:0], outs)
      end
      $display("rows done");
      apb(1'b1, `OFS_GATE_CFG, 32'h0);
      apb(1'b1, `OFS_AN_GAIN, 32'h00000064);
      apb(1'b1, `OFS_AN_OFFSET, 32'hffffff38);
      level <= 13'h007f;
      analog_input_terminal_in <= 14'h2ee0;
      clk(4010);
      `CHK("open gates", 3'h5, outs[2:0])
      `CHK("scaled", 16'h0320, scaled_analog_value_out)
      apb(1'b0, `OFS_AN_STAT, 32'h0);
      `CHK("internal", 11'h3e8, q[10:0])
      apb(1'b1, `OFS_SF_PARAM, 32'h00000102);
      apb(1'b1, `OFS_SF_CFG, 32'h0000021f);
      apb(1'b0, `OFS_SF_PARAM, 32'h0);
      `CHK("param view", 32'h0, q)
      apb(1'b0, `OFS_SF_MSG, 32'h0);
      `CHK("msg view", 32'h00000102, q)
      apb(1'b1, `OFS_SF_CFG, 32'h00000a1f);
      apb(1'b0, `OFS_SF_PARAM, 32'h0);
      `CHK("prog view", 32'h00000102, q)
      $display("analog and protection done");
      // timer of two hundredths: needs three strobes once trigger settles
      apb(1'b1, `OFS_SF_CFG, 32'h00000024);
      apb(1'b1, `OFS_SF_PARAM, 32'h00000002);
      level <= 13'h1200;
      clk(4010);
      `CHK("timer early", 1'b0, sf_q_out)
      clk(8020);
      `CHK("timer done", 1'b1, sf_q_out)
      apb(1'b1, `OFS_SF_CFG, 32'h00000124);
      apb(1'b1, `OFS_SF_CFG, 32'h00001124);
      `CHK("retained", 1'b1, sf_q_out)
      apb(1'b1, `OFS_SF_CFG, 32'h00000024);
      apb(1'b1, `OFS_SF_CFG, 32'h00001024);
      `CHK("restarted", 1'b0, sf_q_out)
      // late reference edge past half a second issues the second early
      apb(1'b1, `OFS_RTC_TIME, 32'h0);
      clk(1100);
      ref_sec <= 1'b1;
      clk(10);
      apb(1'b0, `OFS_RTC_TIME, 32'h0);
      `CHK("ref second", 32'h00000001, q)
      $display("timer restart and reference done");
      rst_b_in <= 1'b0;
      backup_lost_in <= 1'b1;
      clk(6);
      rst_b_in <= 1'b1;
      clk(8);
      `CHK("stop flash", 2'h3, {clock_stopped_out, clock_flash_out})
      apb(1'b0, `OFS_RTC_TIME, 32'h0);
      `CHK("rtc time", 32'h80000000, q)
      $display("backup done");
      end_of_test();
   end
   // watchdog: about 80000 clocks, well past the expected run
   initial begin
      #2000000;
      errors++;
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
